// >>> asr_pkg.sv
package asr_pkg;

    // serial word layout
    localparam int DATA_W = 24;
    localparam int CMD_BITS = 8;
    localparam int NREG = 9;
    localparam int SEL_W = 4;
    localparam int CMD_RD_BIT = 6;
    localparam logic [SEL_W-1:0] DATA_IDX = 4'h4;
    localparam int CNT_W = 5;

    // reset values
    localparam logic [DATA_W-1:0] REG_RST = 24'h000000;
    localparam logic [CMD_BITS-1:0] CMD_RST = 8'h00;

    // time the data register is busy updating, ns, and the cycles it takes at 20 MHz
    localparam int CLK_NS = 50;
    localparam int UPD_NS = 1000;
    localparam int UPD_CYC_I = (UPD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [CNT_W-1:0] UPD_CYC = UPD_CYC_I[CNT_W-1:0];

    typedef enum logic [1:0] {
        ST_CMD,
        ST_RD,
        ST_WR,
        ST_PUSH
    } asr_state_t;

    // one register write handed to the rest of the converter
    typedef struct packed {
        logic [SEL_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } asr_wr_t;

endpackage

// >>> asr_serial_ready.sv
`timescale 1ns/1ps
`default_nettype none

module asr_serial_ready (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic sync_n,
    output logic dout,
    output logic rdy_n,
    output logic filt_rst,
    input wire logic cal_mode,
    input wire logic conv_update,
    input wire logic [asr_pkg::DATA_W-1:0] conv_data,
    input wire logic cal_start,
    input wire logic cal_done,
    output logic wr_valid,
    output asr_pkg::asr_wr_t wr_word,
    input wire logic wr_ready
);
    import asr_pkg::*;

    // pin synchronisers: stage 1 feeds only stage 2
    logic [3:0] pin_s1_q, pin_s2_q;
    logic sclk_p_q;
    logic sclk_s, cs_s, din_s, sync_s, rise, fall;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_s1_q <= 4'hf;
            pin_s2_q <= 4'hf;
            sclk_p_q <= 1'b1;
        end else begin
            pin_s1_q <= {sclk, cs_n, din, sync_n};
            pin_s2_q <= pin_s1_q;
            sclk_p_q <= pin_s2_q[3];
        end
    end
    assign sclk_s = pin_s2_q[3];
    assign cs_s = pin_s2_q[2];
    assign din_s = pin_s2_q[1];
    assign sync_s = pin_s2_q[0];
    // din travels with sclk through equal delay, so it is stable at the rise
    assign rise = sclk_s & ~sclk_p_q;
    assign fall = ~sclk_s & sclk_p_q;

    // register bank and serial engine state
    logic [DATA_W-1:0] regs_q [NREG];
    logic [DATA_W-1:0] regs_d [NREG];
    asr_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [DATA_W-1:0] ish_q, ish_d, osh_q, osh_d;
    logic [CMD_BITS-1:0] cmd_q, cmd_d;
    logic dout_q, dout_d;
    logic push, rd_done, in_ready;
    logic [SEL_W-1:0] sel;
    assign sel = cmd_q[SEL_W-1:0];

    // serial command, read and write sequencing
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        ish_d = ish_q;
        osh_d = osh_q;
        cmd_d = cmd_q;
        dout_d = dout_q;
        push = 1'b0;
        rd_done = 1'b0;
        if (cs_s) begin
            // deselect acts as frame sync; tied low it never fires
            st_d = ST_CMD;
            cnt_d = '0;
        end else begin
            case (st_q)
                ST_CMD: begin
                    if (rise) begin
                        ish_d = {ish_q[DATA_W-2:0], din_s};
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == 5'(CMD_BITS - 1)) begin
                            cnt_d = '0;
                            cmd_d = ish_d[CMD_BITS-1:0];
                            if (ish_d[SEL_W-1:0] < 4'(NREG)) begin
                                if (ish_d[CMD_RD_BIT]) begin
                                    osh_d = regs_q[ish_d[SEL_W-1:0]];
                                    st_d = ST_RD;
                                end else begin
                                    st_d = ST_WR;
                                end
                            end
                        end
                    end
                end
                ST_RD: begin
                    // present on the fall, host samples on the next rise
                    if (fall) begin
                        dout_d = osh_q[DATA_W-1];
                        osh_d = {osh_q[DATA_W-2:0], 1'b0};
                    end
                    if (rise) begin
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == 5'(DATA_W - 1)) begin
                            cnt_d = '0;
                            rd_done = 1'b1;
                            st_d = ST_CMD;
                        end
                    end
                end
                ST_WR: begin
                    if (rise) begin
                        ish_d = {ish_q[DATA_W-2:0], din_s};
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == 5'(DATA_W - 1)) begin
                            cnt_d = '0;
                            st_d = ST_PUSH;
                        end
                    end
                end
                ST_PUSH: begin
                    // a full buffer stalls here; clock edges meanwhile are lost
                    if (in_ready) begin
                        push = 1'b1;
                        st_d = ST_CMD;
                    end
                end
                default: begin
                    st_d = ST_CMD;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= ST_CMD;
            cnt_q <= '0;
            ish_q <= REG_RST;
            osh_q <= REG_RST;
            cmd_q <= CMD_RST;
            dout_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ish_q <= ish_d;
            osh_q <= osh_d;
            cmd_q <= cmd_d;
            dout_q <= dout_d;
        end
    end

    // conversion update window and ready status
    logic [CNT_W-1:0] upd_q, upd_d;
    logic [DATA_W-1:0] pend_q, pend_d;
    logic rdy_q, rdy_d, filt_q, filt_d;
    always_comb begin
        upd_d = upd_q;
        pend_d = pend_q;
        rdy_d = rdy_q;
        filt_d = ~sync_s;
        if (upd_q != '0) begin
            upd_d = upd_q - 5'h01;
        end else if (conv_update && !cal_mode) begin
            upd_d = UPD_CYC;
            pend_d = conv_data;
        end
        if (cal_mode) begin
            if (cal_start) begin
                rdy_d = 1'b1;
            end else if (cal_done) begin
                rdy_d = 1'b0;
            end
        end else if (upd_q == 5'h01) begin
            rdy_d = 1'b0;
        end else if (upd_q != '0 || conv_update) begin
            // raised before the register changes, so a read is not begun
            rdy_d = 1'b1;
        end else if (rd_done && sel == DATA_IDX) begin
            rdy_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            upd_q <= '0;
            pend_q <= REG_RST;
            rdy_q <= 1'b1;
            filt_q <= 1'b1;
        end else begin
            upd_q <= upd_d;
            pend_q <= pend_d;
            rdy_q <= rdy_d;
            filt_q <= filt_d;
        end
    end

    // per-register update: host writes, data register from conversions only
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        always_comb begin
            regs_d[i] = regs_q[i];
            if (SEL_W'(i) == DATA_IDX) begin
                if (upd_q == 5'h01) begin
                    regs_d[i] = pend_q;
                end
            end else if (push && sel == SEL_W'(i)) begin
                regs_d[i] = ish_q;
            end
        end
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                regs_q[i] <= REG_RST;
            end else begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    // two-entry write buffer: head drives the outputs, tail catches a stall
    asr_wr_t head_q, head_d, tail_q, tail_d, push_word;
    logic head_v_q, head_v_d, tail_v_q, tail_v_d, pop;
    assign in_ready = ~tail_v_q;
    assign push_word = '{addr: sel, data: ish_q};
    assign pop = head_v_q & wr_ready;
    always_comb begin
        head_d = head_q;
        tail_d = tail_q;
        head_v_d = head_v_q;
        tail_v_d = tail_v_q;
        if (pop) begin
            head_d = tail_v_q ? tail_q : push_word;
            head_v_d = tail_v_q | push;
            tail_v_d = 1'b0;
        end else if (push) begin
            if (!head_v_q) begin
                head_d = push_word;
                head_v_d = 1'b1;
            end else begin
                tail_d = push_word;
                tail_v_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            head_q <= '0;
            tail_q <= '0;
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
        end else begin
            head_q <= head_d;
            tail_q <= tail_d;
            head_v_q <= head_v_d;
            tail_v_q <= tail_v_d;
        end
    end

    assign dout = dout_q;
    assign rdy_n = rdy_q;
    assign filt_rst = filt_q;
    assign wr_valid = head_v_q;
    assign wr_word = head_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_rdy_low_fresh: assert property (!cal_mode && upd_q == 5'h01 |=> !rdy_q)
        else $error("ready not low after data update");
    a_rdy_high_read: assert property (!cal_mode && rd_done && sel == DATA_IDX |=> rdy_q)
        else $error("ready not high after data read");
    a_rdy_update_hold: assert property (!cal_mode && !$past(cal_mode) && upd_q != '0 && upd_q != 5'h01
        |=> rdy_q)
        else $error("ready low during data update");
    a_data_load_time: assert property (!cal_mode && upd_q == '0 && conv_update
        |=> ##(UPD_CYC_I) regs_q[DATA_IDX] == $past(conv_data, UPD_CYC_I + 1))
        else $error("data register not loaded after update window");
    a_cal_ready: assert property (cal_mode && cal_start |=> rdy_q)
        else $error("ready not high at calibration start");
    a_cal_done: assert property (cal_mode && !cal_start && cal_done |=> !rdy_q)
        else $error("ready not low at calibration end");
    a_dout_shift: assert property (!cs_s && st_q == ST_RD && fall |=> dout_q == $past(osh_q[DATA_W-1]))
        else $error("serial output not from shift register");
    a_dout_on_fall: assert property ($changed(dout_q) |-> $past(fall))
        else $error("serial output changed off a falling edge");
    a_load_select: assert property (!cs_s && st_q == ST_CMD && st_d == ST_RD
        |=> osh_q == regs_q[sel])
        else $error("output register not loaded from selected register");
    a_write_reg: assert property (push && sel != DATA_IDX |=> regs_q[$past(sel)] == $past(ish_q))
        else $error("written word not stored");
    a_frame_sync: assert property (cs_s |=> st_q == ST_CMD && cnt_q == '0)
        else $error("deselect did not restart the frame");
    a_filter_reset: assert property (!sync_s |=> filt_q)
        else $error("filter not held in reset");

    c_data_read: cover property (rd_done && sel == DATA_IDX);
    c_buffer_full: cover property (tail_v_q && !wr_ready);
    c_unread_update: cover property (!rdy_q ##1 conv_update);
    c_cal_cycle: cover property (cal_mode && cal_start ##[1:50] cal_done);

endmodule

`default_nettype wire

// >>> asr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the serial port: drives clock, select and data in, samples data out
module asr_host_model (
    input wire logic clk,
    input wire logic dout,
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // clock idles high between frames and between bursts
    // gap: idle clk between bytes; three_wire: select left low after a frame
    int gap;
    logic three_wire;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        gap = 0;
        three_wire = 1'b0;
    end

    // four clk per half gives the 400 ns serial clock
    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    // one frame, command byte then 24 data bits, msb first
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wdat, output logic [23:0] rdat);
        logic [31:0] sh;
        sh = {cmd, wdat};
        rdat = '0;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 0; i < 32; i++) begin
            sclk = 1'b0;
            din = sh[31-i];
            half();
            sclk = 1'b1;
            if (i >= 8) rdat = {rdat[22:0], dout};
            half();
            // bursty clock parks high between bytes, device must keep its place
            if (i % 8 == 7) repeat (gap) @(negedge clk);
        end
        // let the last word land before deselecting
        repeat (8) @(negedge clk);
        // tied-low select: frames follow each other by bit count alone
        if (!three_wire) begin
            cs_n = 1'b1;
            din = ~din; // released line must not keep its level
        end
    endtask
endmodule

`default_nettype wire

// >>> adc_serial_readout_ready_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module adc_serial_readout_ready_tb_top;
    import asr_pkg::*;
    logic clk, sys_rst, sclk, cs_n, din, sync_n, dout, rdy_n, filt_rst, cal_mode;
    logic conv_update, cal_start, cal_done, wr_valid, wr_ready;
    logic [DATA_W-1:0] conv_data, rd;
    logic [DATA_W-1:0] regs [NREG];
    asr_wr_t wr_word;
    asr_wr_t pend[$];
    int errors, total_checks, seed;

    asr_serial_ready i_asr_serial_ready (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
        .cs_n(cs_n), .din(din), .sync_n(sync_n), .dout(dout), .rdy_n(rdy_n),
        .filt_rst(filt_rst), .cal_mode(cal_mode), .conv_update(conv_update),
        .conv_data(conv_data), .cal_start(cal_start), .cal_done(cal_done),
        .wr_valid(wr_valid), .wr_word(wr_word), .wr_ready(wr_ready));
    asr_host_model i_asr_host_model (.clk(clk), .dout(dout), .sclk(sclk), .cs_n(cs_n),
        .din(din));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        ticks(1);
        s = 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // pop the buffer head against the queued model
    task automatic pop();
        asr_wr_t e;
        e = pend.pop_front();
        chk("wr_valid", 32'h1, {31'h0, wr_valid});
        chk("wr_word", {4'h0, e}, {4'h0, wr_word});
        wr_ready = 1'b1;
        ticks(1);
        wr_ready = 1'b0;
        ticks(1);
    endtask

    // new result: ready high over the 20 clk update, low at edge 21
    task automatic conv();
        conv_data = DATA_W'($random(seed));
        pulse(conv_update);
        chk("rdy_n update", 32'h1, {31'h0, rdy_n});
        ticks(19);
        chk("rdy_n update", 32'h1, {31'h0, rdy_n});
        ticks(1);
        chk("rdy_n fresh", 32'h0, {31'h0, rdy_n});
        regs[DATA_IDX] = conv_data;
    endtask

    initial begin
        seed = 32'h2ff3353a;
        {sys_rst, sync_n} = 2'b11;
        {cal_mode, conv_update, cal_start, cal_done, wr_ready} = 5'h00;
        conv_data = '0;
        errors = 0;
        total_checks = 0;
        foreach (regs[i]) regs[i] = REG_RST;
        ticks(16);
        sys_rst = 1'b0;
        ticks(4);
        chk("rdy_n reset", 32'h1, {31'h0, rdy_n});
        chk("wr_valid reset", 32'h0, {31'h0, wr_valid});
        // writes land in the buffer; consumer stalls until two are queued
        for (int s = 0; s < NREG; s++) begin
            if (s != DATA_IDX) begin
                logic [23:0] d;
                d = 24'($random(seed));
                i_asr_host_model.xfer({4'h0, s[3:0]}, d, rd);
                regs[s] = d;
                pend.push_back({s[3:0], d});
                if (pend.size() == 2) begin
                    pop();
                    pop();
                end
            end
        end
        while (pend.size() > 0) pop();
        chk("wr_valid drained", 32'h0, {31'h0, wr_valid});
        $display("test write done");
        // read back every register but the data register, bursty clock, select tied low
        i_asr_host_model.gap = 12;
        i_asr_host_model.three_wire = 1'b1;
        for (int s = 0; s < NREG; s++) begin
            if (s != DATA_IDX) begin
                i_asr_host_model.xfer({4'h4, s[3:0]}, 24'h0, rd);
                chk("read reg", {8'h0, regs[s]}, {8'h0, rd});
            end
        end
        i_asr_host_model.gap = 0;
        i_asr_host_model.three_wire = 1'b0;
        $display("test read done");
        // first result left unread when the second arrives
        conv();
        conv();
        i_asr_host_model.xfer({4'h4, DATA_IDX}, 24'h0, rd);
        chk("data reg", {8'h0, regs[DATA_IDX]}, {8'h0, rd});
        chk("rdy_n after read", 32'h1, {31'h0, rdy_n});
        $display("test conversion done");
        cal_mode = 1'b1;
        pulse(cal_done);
        chk("rdy_n cal", 32'h0, {31'h0, rdy_n});
        pulse(cal_start);
        chk("rdy_n cal", 32'h1, {31'h0, rdy_n});
        ticks(3);
        pulse(cal_done);
        chk("rdy_n cal", 32'h0, {31'h0, rdy_n});
        cal_mode = 1'b0;
        $display("test calibration done");
        sync_n = 1'b0;
        ticks(4);
        chk("filt_rst", 32'h1, {31'h0, filt_rst});
        sync_n = 1'b1;
        ticks(4);
        chk("filt_rst", 32'h0, {31'h0, filt_rst});
        $display("test sync done");
        final_report();
    end

    // about six times the expected run length
    initial begin
        ticks(30000);
        errors++;
        $display("watchdog expired");
        final_report();
    end
endmodule

`default_nettype wire
